// ===== inc/mcc_map.svh
/*
 * constants of the calibration correction block: register indexes,
 * reset values, field positions and timing counts.
 * assumes it is included by the principal design file and by the bench.
 */
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH

// register indexes on the plain register port
`define MCC_REG_PHASE    4'h0
`define MCC_REG_VOFF     4'h1
`define MCC_REG_IOFF     4'h2
`define MCC_REG_GAIN     4'h3
`define MCC_REG_DIV      4'h4
`define MCC_REG_LINECYC  4'h5
`define MCC_REG_STATUS   4'h6
`define MCC_REG_MASK     4'h7
`define MCC_REG_VOLTAGE_RMS_VALUE     4'h8
`define MCC_REG_CURRENT_RMS_VALUE     4'h9
`define MCC_REG_VAE      4'ha
`define MCC_REG_LACT     4'hb
`define MCC_REG_LAPP     4'hc

// reset values
`define MCC_RST_PHASE    6'h0d
`define MCC_RST_DIV      8'h00
`define MCC_RST_LINECYC  16'hffff

// phase trim: zero point, clocks per step, fixed alignment base
`define MCC_TRIM_ZERO    11'sh00d
`define MCC_TRIM_STEP    11'sh008
`define MCC_ALIGN_BASE   11'sh168

// datapath scaling
`define MCC_LPF_SHIFT    5
`define MCC_IOFF_SCALE   15
`define MCC_GAIN_ONE     14'sh1000
`define MCC_GAIN_FRAC    12
`define MCC_VA_DROP      16
`define MCC_ACT_DROP     16

// iteration end points
`define MCC_SQ_LAST      4'hf
`define MCC_DIV_LAST     5'h17

// status and mask bit positions
`define MCC_ST_ZX        0
`define MCC_ST_LC        1
`define MCC_ST_RMS       2

`endif

// ===== inc/mcc_pkg.sv
/*
 * types of the calibration correction block.
 * assumes the converters deliver one sample pair per strobe.
 */
package mcc_pkg;

  // one sample pair from the converter channels
  typedef struct packed {
    logic               valid;
    logic signed [15:0] cur;
    logic signed [15:0] volt;
  } mcc_sample_t;

  // one register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [23:0] wdata;
  } mcc_bus_t;

  // sequencer of the shared root and divider unit
  typedef enum logic [1:0] {
    MCC_IDLE,
    MCC_SQV,
    MCC_SQI,
    MCC_DIV
  } mcc_state_t;

endpackage

// ===== hw/mcc_top.sv
/*
 * calibration correction datapath: phase trim alignment, rms with
 * offset correction, apparent energy gain and divider, zero crossing
 * and line cycle accumulation, register port and interrupt.
 * assumes sample strobes at least 512 clocks apart, synchronous to clk.
 */
`timescale 1ns/10ps
`include "mcc_map.svh"

// Notes on behaviour
// RL1: voltage shift is (trim minus 13) times 8 clocks
// RL2: positive delays, negative advances, 13 means none
// RL3: phase trim is signed two's complement
// RL4: trim span covers 1.84 lead, 0.72 lag
// RL5: rms is root of filtered square
// RL6: voltage rms offset added after root
// RL7: current offset times 32768 added before root
// RL8: apparent energy over divider, times gain term
// RL9: zero crossings can drive the interrupt
// RL10: host reads both line results per interrupt
// RL11: host calibrates apparent gain before rms offsets
// RL12: host drops first line result, reads promptly
// RL13: negative current radicand clamps to zero
module mcc_top
  import mcc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // converter samples
  input  wire mcc_sample_t smp,
  // register port
  input  wire mcc_bus_t    bus,
  output logic [23:0]      rdata,
  // interrupt, active high level
  output logic             irq
);

  logic [5:0]         phase_trim_q;
  logic [11:0]        voltage_rms_offset_q;
  logic [11:0]        current_rms_offset_q;
  logic [11:0]        apparent_gain_trim_q;
  logic [7:0]         apparent_divider_q;
  logic [15:0]        line_cycles_q;
  logic [2:0]         status_q;
  logic [2:0]         mask_q;
  logic [15:0]        voltage_rms_value_q;
  logic [15:0]        current_rms_value_q;
  logic [23:0]        apparent_energy_accum_q;
  logic [23:0]        line_cycle_active_accum_q;
  logic [23:0]        line_cycle_apparent_accum_q;
  logic [23:0]        rdata_q;
  logic               irq_q;
  logic [9:0]         cnt_q [2];
  logic               pend_q [2];
  logic signed [15:0] hold_q [2];
  logic               rel_stb_q [2];
  logic signed [15:0] rel_q [2];
  logic [31:0]        lpf_q [2];
  logic signed [15:0] smp_ch [2];
  logic [9:0]         ld_cnt [2];
  logic               volt_neg_q;
  mcc_state_t         state_q;
  logic [4:0]         it_q;
  logic               seq_go_q;
  logic [15:0]        root_q;
  logic [31:0]        rad_q;
  logic [23:0]        dv_q;
  logic [23:0]        quo_q;
  logic [8:0]         rem_q;
  logic [7:0]         residue_q;
  logic [15:0]        vrms0_q;
  logic [15:0]        lc_cnt_q;
  logic [23:0]        run_act_q;
  logic [23:0]        run_app_q;

  // register port decode
  wire wr_phase = bus.wr && bus.addr == `MCC_REG_PHASE;
  wire wr_voff  = bus.wr && bus.addr == `MCC_REG_VOFF;
  wire wr_ioff  = bus.wr && bus.addr == `MCC_REG_IOFF;
  wire wr_gain  = bus.wr && bus.addr == `MCC_REG_GAIN;
  wire wr_div   = bus.wr && bus.addr == `MCC_REG_DIV;
  wire wr_lcyc  = bus.wr && bus.addr == `MCC_REG_LINECYC;
  wire wr_stat  = bus.wr && bus.addr == `MCC_REG_STATUS;
  wire wr_mask  = bus.wr && bus.addr == `MCC_REG_MASK;

  // signed trim offset from the zero point, in steps
  wire logic signed [10:0] trim_shift =
    11'($signed(phase_trim_q)) - `MCC_TRIM_ZERO;                  // [RL3]
  // current waits the base; voltage waits base plus shifted steps
  assign ld_cnt[0] = 10'(`MCC_ALIGN_BASE);
  assign ld_cnt[1] = 10'(`MCC_ALIGN_BASE
                     + 11'(trim_shift * `MCC_TRIM_STEP));      // [RL1] [RL2]
  assign smp_ch[0] = smp.cur;
  assign smp_ch[1] = smp.volt;

  // per channel alignment delay and squaring low pass filter
  // a fixed base lets a negative trim advance voltage against current
  genvar g;
  for (g = 0; g < 2; g++) begin : g_chan
    wire               rel   = pend_q[g] && cnt_q[g] == 10'h000;
    wire logic [31:0]  sq    =                                      // [RL5]
      $unsigned(32'(rel_q[g]) * 32'(rel_q[g]));
    wire logic signed [32:0] diff =
      $signed({1'b0, sq}) - $signed({1'b0, lpf_q[g]});
    wire logic [31:0]  lpf_d =
      32'($signed({1'b0, lpf_q[g]}) + (diff >>> `MCC_LPF_SHIFT));

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cnt_q[g]     <= 10'h000;
        pend_q[g]    <= 1'b0;
        hold_q[g]    <= 16'sh0000;
        rel_stb_q[g] <= 1'b0;
        rel_q[g]     <= 16'sh0000;
        lpf_q[g]     <= 32'h0000_0000;
      end else begin
        rel_stb_q[g] <= rel;
        if (rel) rel_q[g] <= hold_q[g];
        if (rel_stb_q[g]) lpf_q[g] <= lpf_d;                     // [RL5]
        if (smp.valid) begin
          hold_q[g] <= smp_ch[g];
          cnt_q[g]  <= ld_cnt[g];                                // [RL1]
          pend_q[g] <= 1'b1;
        end else if (rel) begin
          pend_q[g] <= 1'b0;
        end else if (pend_q[g]) begin
          cnt_q[g] <= cnt_q[g] - 10'h001;
        end
      end
    end
  end

  // zero crossing: sign change of the aligned voltage
  wire zx_ev = rel_stb_q[1] && (rel_q[1][15] != volt_neg_q);      // [RL9]

  // current radicand with offset, clamped at zero and at full scale
  wire logic signed [34:0] irad_s = $signed({3'b000, lpf_q[0]})
    + (35'($signed(current_rms_offset_q)) <<< `MCC_IOFF_SCALE);  // [RL7]
  wire logic [31:0] irad = irad_s[34] ? 32'h0000_0000 :           // [RL13]
                           (|irad_s[33:32]) ? 32'hffff_ffff : irad_s[31:0];

  // one bit per clock root: keep the trial bit if its square fits
  wire logic [15:0] trial  = root_q | (16'h0001 << it_q[3:0]);
  wire logic [31:0] tsq    = 32'(trial) * 32'(trial);
  wire logic [15:0] root_d = (tsq <= rad_q) ? trial : root_q;     // [RL5]
  wire sq_last = (state_q == MCC_SQV || state_q == MCC_SQI)
                 && it_q[3:0] == 4'h0;

  // voltage offset applied to the finished root
  wire logic [15:0] voltage_rms_value_corr =
    16'(root_d + 16'($signed(voltage_rms_offset_q)));             // [RL6]

  // apparent value with gain term, coarsened before the divide
  wire logic signed [13:0] gain_mul =
    `MCC_GAIN_ONE + 14'($signed(apparent_gain_trim_q));           // [RL8]
  wire logic [31:0] va_raw = 32'(vrms0_q) * 32'(root_d);
  wire logic signed [46:0] va_gain =
    $signed({1'b0, va_raw}) * 47'(gain_mul);
  wire logic [46:0] va_pos = va_gain[46] ? 47'h0 : 47'($unsigned(va_gain));
  wire logic [23:0] va_div_in = 24'(va_pos >> (`MCC_GAIN_FRAC
                                + `MCC_VA_DROP)) + 24'(residue_q);

  // restoring divide by the divider, zero acts as one
  wire logic [7:0] divisor = (apparent_divider_q == 8'h00) ? 8'h01
                             : apparent_divider_q;
  wire logic [8:0] rem_sh  = {rem_q[7:0], dv_q[23]};
  wire             q_bit   = rem_sh >= {1'b0, divisor};
  wire logic [8:0] rem_nx  = q_bit ? rem_sh - {1'b0, divisor} : rem_sh;
  wire logic [23:0] quot_fin = {quo_q[22:0], q_bit};              // [RL8]
  wire div_last = state_q == MCC_DIV && it_q == 5'h00;

  // active product per aligned current sample
  wire logic signed [31:0] prod = rel_q[1] * rel_q[0];
  wire logic [23:0] act_add = rel_stb_q[0] ?
    24'(prod >>> `MCC_ACT_DROP) : 24'h000000;
  wire logic [23:0] app_add = div_last ? quot_fin : 24'h000000;
  wire lc_done = zx_ev && (lc_cnt_q + 16'h0001 >= line_cycles_q);

  // status: hardware set wins over a write-one clear
  wire logic [2:0] ev;
  assign ev[`MCC_ST_ZX]  = zx_ev;
  assign ev[`MCC_ST_LC]  = lc_done;
  assign ev[`MCC_ST_RMS] = state_q == MCC_SQI && it_q[3:0] == 4'h0;
  wire logic [2:0] status_d =
    (status_q & ~(wr_stat ? bus.wdata[2:0] : 3'b000)) | ev;

  // read data mux, unmapped indexes read zero
  wire logic [23:0] rd_mux =
    (bus.addr == `MCC_REG_PHASE)   ? {18'h0, phase_trim_q} :
    (bus.addr == `MCC_REG_VOFF)    ? {12'h0, voltage_rms_offset_q} :
    (bus.addr == `MCC_REG_IOFF)    ? {12'h0, current_rms_offset_q} :
    (bus.addr == `MCC_REG_GAIN)    ? {12'h0, apparent_gain_trim_q} :
    (bus.addr == `MCC_REG_DIV)     ? {16'h0, apparent_divider_q} :
    (bus.addr == `MCC_REG_LINECYC) ? {8'h0, line_cycles_q} :
    (bus.addr == `MCC_REG_STATUS)  ? {21'h0, status_q} :
    (bus.addr == `MCC_REG_MASK)    ? {21'h0, mask_q} :
    (bus.addr == `MCC_REG_VOLTAGE_RMS_VALUE)    ? {8'h0, voltage_rms_value_q} :
    (bus.addr == `MCC_REG_CURRENT_RMS_VALUE)    ? {8'h0, current_rms_value_q} :
    (bus.addr == `MCC_REG_VAE)     ? apparent_energy_accum_q :
    (bus.addr == `MCC_REG_LACT)    ? line_cycle_active_accum_q :
    (bus.addr == `MCC_REG_LAPP)    ? line_cycle_apparent_accum_q :
                                     24'h000000;

  // software registers, status, interrupt and read data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_trim_q         <= `MCC_RST_PHASE;
      voltage_rms_offset_q <= 12'h000;
      current_rms_offset_q <= 12'h000;
      apparent_gain_trim_q <= 12'h000;
      apparent_divider_q   <= `MCC_RST_DIV;
      line_cycles_q        <= `MCC_RST_LINECYC;
      status_q             <= 3'b000;
      mask_q               <= 3'b000;
      rdata_q              <= 24'h000000;
      irq_q                <= 1'b0;
    end else begin
      if (wr_phase) phase_trim_q <= bus.wdata[5:0];
      if (wr_voff)  voltage_rms_offset_q <= bus.wdata[11:0];
      if (wr_ioff)  current_rms_offset_q <= bus.wdata[11:0];
      if (wr_gain)  apparent_gain_trim_q <= bus.wdata[11:0];
      if (wr_div)   apparent_divider_q <= bus.wdata[7:0];
      if (wr_lcyc)  line_cycles_q <= bus.wdata[15:0];
      if (wr_mask)  mask_q <= bus.wdata[2:0];
      status_q <= status_d;
      irq_q    <= |(status_d & mask_q);                           // [RL9]
      rdata_q  <= bus.rd ? rd_mux : 24'h000000;
    end
  end

  // root and divide sequencer; a sample arriving while busy is skipped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= MCC_IDLE;
      seq_go_q <= 1'b0;
      it_q     <= 5'h00;
      root_q   <= 16'h0000;
      rad_q    <= 32'h0000_0000;
      dv_q     <= 24'h000000;
      quo_q    <= 24'h000000;
      rem_q    <= 9'h000;
      residue_q <= 8'h00;
      vrms0_q  <= 16'h0000;
      voltage_rms_value_q     <= 16'h0000;
      current_rms_value_q     <= 16'h0000;
      apparent_energy_accum_q <= 24'h000000;
    end else begin
      // start one clock after the current release, so that a voltage
      // sample released in the same clock is already in its filter;
      // a voltage released later reaches the root one sample late
      seq_go_q <= rel_stb_q[0];
      case (state_q)
        MCC_IDLE: if (seq_go_q) begin
          state_q <= MCC_SQV;
          it_q    <= {1'b0, `MCC_SQ_LAST};
          root_q  <= 16'h0000;
          rad_q   <= lpf_q[1];                                    // [RL5]
        end
        MCC_SQV: begin
          root_q <= root_d;
          it_q   <= it_q - 5'h01;
          if (sq_last) begin
            vrms0_q             <= root_d;
            voltage_rms_value_q <= voltage_rms_value_corr;                     // [RL6]
            state_q <= MCC_SQI;
            it_q    <= {1'b0, `MCC_SQ_LAST};
            root_q  <= 16'h0000;
            rad_q   <= irad;                                 // [RL7] [RL13]
          end
        end
        MCC_SQI: begin
          root_q <= root_d;
          it_q   <= it_q - 5'h01;
          if (sq_last) begin
            current_rms_value_q <= root_d;
            state_q <= MCC_DIV;
            it_q    <= `MCC_DIV_LAST;
            dv_q    <= va_div_in;                                 // [RL8]
            quo_q   <= 24'h000000;
            rem_q   <= 9'h000;
          end
        end
        MCC_DIV: begin
          dv_q  <= {dv_q[22:0], 1'b0};
          quo_q <= quot_fin;
          rem_q <= rem_nx;
          it_q  <= it_q - 5'h01;
          if (div_last) begin
            residue_q <= rem_nx[7:0];
            apparent_energy_accum_q <=
              apparent_energy_accum_q + quot_fin;                 // [RL8]
            state_q <= MCC_IDLE;
          end
        end
        default: state_q <= MCC_IDLE;
      endcase
    end
  end

  // zero crossing and line cycle accumulation
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      volt_neg_q <= 1'b0;
      lc_cnt_q   <= 16'h0000;
      run_act_q  <= 24'h000000;
      run_app_q  <= 24'h000000;
      line_cycle_active_accum_q   <= 24'h000000;
      line_cycle_apparent_accum_q <= 24'h000000;
    end else begin
      if (rel_stb_q[1]) volt_neg_q <= rel_q[1][15];
      if (lc_done) begin
        lc_cnt_q  <= 16'h0000;
        line_cycle_active_accum_q   <= run_act_q;
        line_cycle_apparent_accum_q <= run_app_q;
        run_act_q <= act_add;
        run_app_q <= app_add;
      end else begin
        if (zx_ev) lc_cnt_q <= lc_cnt_q + 16'h0001;
        run_act_q <= run_act_q + act_add;
        run_app_q <= run_app_q + app_add;
      end
    end
  end

  assign rdata = rdata_q;
  assign irq   = irq_q;

  // checks
  property p_shift;
    @(posedge clk) disable iff (!resetn)
    smp.valid |=> cnt_q[1] == 10'(`MCC_ALIGN_BASE + 11'((11'($signed(
      $past(phase_trim_q))) - `MCC_TRIM_ZERO) * `MCC_TRIM_STEP));
  endproperty
  a_shift: assert property (p_shift) else $error("bad voltage shift"); // [RL1]

  property p_dir;
    @(posedge clk) disable iff (!resetn)
    smp.valid |=> (phase_trim_q == `MCC_RST_PHASE) == (cnt_q[1] == cnt_q[0]);
  endproperty
  a_dir: assert property (p_dir) else $error("zero trim not neutral"); // [RL2]

  property p_sign;
    @(posedge clk) disable iff (!resetn)
    smp.valid && phase_trim_q[5] |=> cnt_q[1] < cnt_q[0];
  endproperty
  a_sign: assert property (p_sign) else $error("negative trim not early"); // [RL3]

  property p_range;
    @(posedge clk) disable iff (!resetn)
    smp.valid |=> cnt_q[1] <= 10'h1f8;
  endproperty
  a_range: assert property (p_range) else $error("trim span exceeded"); // [RL4]

  property p_root;
    @(posedge clk) disable iff (!resetn)
    sq_last |-> 33'(root_d) * 33'(root_d) <= 33'(rad_q)
      && (33'(root_d) + 33'h1) * (33'(root_d) + 33'h1) > 33'(rad_q);
  endproperty
  a_root: assert property (p_root) else $error("root not exact"); // [RL5]

  property p_voff;
    @(posedge clk) disable iff (!resetn)
    state_q == MCC_SQV && sq_last |=> voltage_rms_value_q == 16'(vrms0_q
      + 16'($signed($past(voltage_rms_offset_q))));
  endproperty
  a_voff: assert property (p_voff) else $error("voltage offset wrong"); // [RL6]

  property p_irad;
    @(posedge clk) disable iff (!resetn)
    state_q == MCC_SQV && sq_last && !irad_s[34] && !(|irad_s[33:32])
      |=> state_q == MCC_SQI && 35'(rad_q) == $past(irad_s);
  endproperty
  a_irad: assert property (p_irad) else $error("current offset wrong"); // [RL7]

  property p_clamp;
    @(posedge clk) disable iff (!resetn)
    state_q == MCC_SQV && sq_last && irad_s[34]
      |=> rad_q == 32'h0 ##16 current_rms_value_q == 16'h0000;
  endproperty
  a_clamp: assert property (p_clamp) else $error("negative not clamped"); // [RL13]

  property p_energy;
    @(posedge clk) disable iff (!resetn)
    div_last |=> apparent_energy_accum_q
      == $past(apparent_energy_accum_q) + $past(quot_fin);
  endproperty
  a_energy: assert property (p_energy) else $error("energy not added"); // [RL8]

  property p_zx_irq;
    @(posedge clk) disable iff (!resetn)
    zx_ev && mask_q[`MCC_ST_ZX] && !wr_mask |=> irq_q && status_q[`MCC_ST_ZX];
  endproperty
  a_zx_irq: assert property (p_zx_irq) else $error("zero cross no irq"); // [RL9]

endmodule // mcc_top

// ===== verification/mcc_conv_model.sv
/*
 * converter channel model: hands one current and voltage sample pair
 * to the block per request, never closer together than GAP clocks.
 * assumes one-cycle request pulses on go, synchronous to clk.
 */
`timescale 1ns/10ps
module mcc_conv_model
  import mcc_pkg::*;
#(
  parameter int GAP = 600
)(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // request from the bench
  input  wire logic               go,
  input  wire logic signed [15:0] v_in,
  input  wire logic signed [15:0] c_in,
  // sample stream into the block
  output mcc_sample_t             smp
);
  logic        pend_q;
  logic [15:0] v_q;
  logic [15:0] c_q;
  logic [15:0] noise_q;
  logic [9:0]  gap_q;

  // the strobe waits out the spacing; between strobes the data lines
  // churn every cycle, so a stale pair can never pass for a fresh one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_q  <= 1'b0;
      v_q     <= 16'h0000;
      c_q     <= 16'h0000;
      noise_q <= 16'h0000;
      gap_q   <= 10'(GAP);
      smp     <= '0;
    end else begin
      noise_q <= noise_q + 16'h3b5d;
      if (go) begin
        pend_q <= 1'b1;
        v_q    <= v_in;
        c_q    <= c_in;
      end
      if (pend_q && gap_q >= 10'(GAP)) begin
        smp    <= '{valid: 1'b1, cur: c_q, volt: v_q};
        pend_q <= 1'b0;
        gap_q  <= 10'h000;
      end else begin
        smp <= '{valid: 1'b0, cur: noise_q, volt: ~noise_q};
        if (gap_q < 10'(GAP)) gap_q <= gap_q + 10'h001;
      end
    end
  end
endmodule // mcc_conv_model

// ===== verification/tb_top.sv
/*
 * self-checking bench for the calibration correction block.
 * assumes the converter model as sample source; reads are noted in
 * a queue and compared by a monitor in the cycle after the strobe.
 */
`timescale 1ns/10ps
`include "mcc_map.svh"
module tb_top;
  import mcc_pkg::*;
  typedef struct {string nm; logic [23:0] ex; logic [23:0] mk;} mcc_note_t;
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  logic               go = 1'b0;
  logic               rd_taken = 1'b0;
  logic signed [15:0] v_in = 16'sh0000;
  logic signed [15:0] c_in = 16'sh0000;
  logic [23:0]        rdata;
  logic               irq;
  mcc_sample_t        smp;
  mcc_bus_t           bus = '0;
  mcc_note_t          notes[$];
  int                 fails = 0, samples_checked = 0, seed = 35;
  int                 i, k, n, n0, got;
  logic [31:0]        r1, r2, r3;
  longint             accv, acci, ea, res, lq, win;
  logic [5:0]         trims [4] = '{6'h0d, 6'h1f, 6'h20, 6'h3f};
  logic [23:0]        wm [8] = '{24'h3f, 24'hfff, 24'hfff, 24'hfff,
                                 24'hff, 24'hffff, 24'h0, 24'h7};

  always #12.5 clk = ~clk;

  mcc_top mcc_top_inst (.clk(clk), .resetn(resetn), .smp(smp), .bus(bus),
                        .rdata(rdata), .irq(irq));
  mcc_conv_model mcc_conv_model_inst (.clk(clk), .resetn(resetn), .go(go),
                                      .v_in(v_in), .c_in(c_in), .smp(smp));

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic fail_out(string nm);
    fails++;
    $display("CHECK FAILED %s expected done seen timeout", nm);
    print_verdict();
  endtask

  task automatic check_val(string nm, logic [23:0] ex, logic [23:0] gv);
    samples_checked++;
    if (gv !== ex) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, gv);
    end
  endtask

  // a zero mask marks a read that is taken but deliberately not judged
  task automatic check_reg(mcc_note_t nt, logic [23:0] gv);
    if (nt.mk != 24'h0) check_val(nt.nm, nt.ex & nt.mk, gv & nt.mk);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) rd_taken <= bus.rd;
  always @(negedge clk) begin
    if (rd_taken) begin
      if (notes.size() == 0) check_val("read note", 24'h0, 24'hffffff);
      else check_reg(notes.pop_front(), rdata);
    end
  end

  task automatic wait_cyc(int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic wr(logic [3:0] a, logic [23:0] d);
    @(posedge clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) bus <= '0;
  endtask

  task automatic rd(logic [3:0] a, logic [23:0] ex, logic [23:0] mk,
                    string nm);
    notes.push_back('{nm, ex, mk});
    @(posedge clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 24'h0};
    @(posedge clk) bus <= '0;
  endtask

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    accv = 0;
    acci = 0;
    ea = 0;
    res = 0;
  endtask

  task automatic send(logic signed [15:0] v, logic signed [15:0] c);
    int t;
    @(posedge clk) go <= 1'b1;
    v_in <= v;
    c_in <= c;
    @(posedge clk) go <= 1'b0;
    for (t = 0; t < 1000 && smp.valid !== 1'b1; t++) @(negedge clk);
    if (t == 1000) fail_out("sample strobe");
  endtask

  function automatic longint isqrt(longint x);
    longint r = 0;
    for (int b = 16; b >= 0; b--)
      if ((r + (64'sd1 << b)) * (r + (64'sd1 << b)) <= x) r += 64'sd1 << b;
    return r;
  endfunction

  // one sample with fresh trims; the model follows the block's arithmetic
  task automatic step(logic signed [15:0] v, logic signed [15:0] c,
                      logic [11:0] vo, logic [11:0] io, logic [11:0] g,
                      logic [7:0] dv);
    longint v0, vr, ir, rad, e, d;
    wr(`MCC_REG_GAIN, {12'h0, g});
    wr(`MCC_REG_DIV, {16'h0, dv});
    wr(`MCC_REG_VOFF, {12'h0, vo});
    wr(`MCC_REG_IOFF, {12'h0, io});
    send(v, c);
    accv += (longint'(v) * v - accv) >>> 5;
    acci += (longint'(c) * c - acci) >>> 5;
    v0 = isqrt(accv);
    vr = (v0 + longint'($signed(vo))) & 64'hffff;
    rad = acci + longint'($signed(io)) * 32768;
    if (rad < 0) rad = 0;
    if (rad > 64'hffffffff) rad = 64'hffffffff;
    ir = isqrt(rad);
    e = (v0 * ir * (4096 + longint'($signed(g)))) >>> 28;
    if (e < 0) e = 0;
    d = (dv == 8'h0) ? 1 : dv;
    e += res;
    lq = e / d;
    ea = (ea + lq) & 64'hffffff;
    res = e % d;
    wait_cyc(600);
    rd(`MCC_REG_VOLTAGE_RMS_VALUE, vr[23:0], 24'hffffff, "voltage_rms_value");
    rd(`MCC_REG_CURRENT_RMS_VALUE, ir[23:0], 24'hffffff, "current_rms_value");
    rd(`MCC_REG_VAE, ea[23:0], 24'hffffff, "apparent energy");
  endtask

  initial begin
    do_reset();
    // reset values, write-read with upper bits cut, ro and unmapped places
    for (i = 0; i < 16; i++)
      rd(4'(i), (i == 0) ? 24'h0d : (i == 5) ? 24'hffff : 24'h0,
         24'hffffff, "reset value");
    for (i = 0; i < 8; i++) begin
      r1 = $random(seed);
      wr(4'(i), r1[23:0]);
      rd(4'(i), r1[23:0] & wm[i], 24'hffffff, "write readback");
    end
    wr(`MCC_REG_VOLTAGE_RMS_VALUE, 24'h00abcd);
    wr(4'he, 24'h123456);
    rd(`MCC_REG_VOLTAGE_RMS_VALUE, 24'h0, 24'hffffff, "read only");
    rd(4'he, 24'h0, 24'hffffff, "unmapped");
    // voltage shift measured as the zero crossing delay against trim 13
    wr(`MCC_REG_MASK, 24'h1);
    for (i = 0; i < 4; i++) begin
      wr(`MCC_REG_PHASE, {18'h0, trims[i]});
      send(16'sh1000, 16'sh1000);
      wait_cyc(560);
      wr(`MCC_REG_STATUS, 24'h7);
      send(-16'sh1000, 16'sh1000);
      for (n = 0; n < 1000 && irq !== 1'b1; n++) @(negedge clk);
      if (n == 1000) fail_out("zero crossing irq");
      if (i == 0) n0 = n;
      else check_val("phase shift", 24'(8 * ($signed(trims[i]) - 13)),
                     24'(n - n0));
    end
    rd(`MCC_REG_STATUS, 24'h1, 24'h1, "zero crossing status");
    wr(`MCC_REG_MASK, 24'h0);
    wait_cyc(2);
    check_val("masked irq", 24'h0, {23'h0, irq});
    wr(`MCC_REG_MASK, 24'h1);
    wait_cyc(2);
    check_val("unmasked irq", 24'h1, {23'h0, irq});
    wr(`MCC_REG_STATUS, 24'h1);
    wait_cyc(2);
    check_val("cleared irq", 24'h0, {23'h0, irq});
    // rms and apparent energy from a fresh filter state
    do_reset();
    step(16'sh4000, 16'sh4000, 12'h800, 12'h000, 12'h000, 8'h00);
    step(16'sh0400, 16'sh0000, 12'h7ff, 12'h800, 12'h7ff, 8'h03);
    step(16'sh0000, 16'sh0200, 12'h100, 12'h002, 12'h800, 8'h01);
    step(16'sh0000, 16'sh0000, 12'h000, 12'h008, 12'h000, 8'hff);
    for (i = 0; i < 6; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      step($signed(r1[13:0]), $signed(r1[29:16]), {1'b0, r2[10:0]},
           r2[22:11], r3[11:0], r3[19:12]);
    end
    // line cycle results: each sample is one half cycle of 4096 product
    wr(`MCC_REG_LINECYC, 24'h4);
    wr(`MCC_REG_MASK, 24'h2);
    wr(`MCC_REG_STATUS, 24'h7);
    got = 0;
    win = 0;
    // a window holds the four samples before the one that closes it
    for (k = 0; k < 40 && got < 3; k++) begin
      step(k[0] ? 16'sh4000 : -16'sh4000, k[0] ? 16'sh4000 : -16'sh4000,
           12'h000, 12'h000, 12'h000, 8'h01);
      win += lq;
      if (irq === 1'b1) begin
        rd(`MCC_REG_LACT, 24'h4000, (got == 0) ? 24'h0 : 24'hffffff,
           "line active");
        rd(`MCC_REG_LAPP, 24'(win - lq), (got == 0) ? 24'h0 : 24'hffffff,
           "line apparent");
        win = lq;
        wr(`MCC_REG_STATUS, 24'h2);
        got++;
      end
    end
    if (got < 3) fail_out("line cycle irq");
    wait_cyc(4);
    print_verdict();
  end
endmodule // tb_top
